// >>> hw/csbe_exec.sv
`timescale 1ns/1ps
`default_nettype none
module csbe_exec #(
  parameter int              AW       = 16,
  parameter logic [15:0]     SP_RESET = 16'h045f
) (
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  // Instruction handshake
  input  wire logic              i_op_valid,
  input  wire csbe_pkg::csbe_op_t i_op,
  input  wire logic [4:0]        i_reg,
  input  wire logic [2:0]        i_bit,
  input  wire logic [15:0]       i_imm,
  output logic                   o_op_ready,
  output logic                   o_op_done,
  // Data memory
  output logic [15:0]            o_dm_addr,
  output logic                   o_dm_we,
  output logic                   o_dm_re,
  output logic [7:0]             o_dm_wdata,
  input  wire logic [7:0]        i_dm_rdata,
  // Program memory, word addressed
  output logic [14:0]            o_pm_addr,
  output logic                   o_pm_re,
  output logic                   o_pm_we,
  output logic [15:0]            o_pm_wdata,
  input  wire logic [15:0]       i_pm_rdata,
  input  wire logic              i_pm_done,
  // I/O space
  output logic [5:0]             o_io_addr,
  output logic                   o_io_re,
  output logic                   o_io_we,
  output logic [7:0]             o_io_wdata,
  input  wire logic [7:0]        i_io_rdata,
  // Control side
  output logic                   o_sleep_req,
  output logic                   o_wdt_restart,
  output logic                   o_debug_halt,
  input  wire logic              i_debug_resume,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata
);

  if (AW != 16) begin : g_aw_check
    $error("csbe_exec: only a 16-bit data address is supported");
  end

  // Architectural state
  logic [7:0]            rf_q [32];
  logic [7:0]            flags_q;
  logic [15:0]           sp_q;
  logic [1:0]            ctrl_q;
  csbe_pkg::csbe_state_t state_q;
  csbe_pkg::csbe_op_t    op_q;
  logic [4:0]            reg_q;
  logic [15:0]           addr_q;
  logic [7:0]            data_q;
  logic [15:0]           pmw_q;
  logic [31:0]           prdata_q;

  // Shift and bit results: {carry out, value}
  function automatic logic [8:0] alu_calc(input csbe_pkg::csbe_op_t op,
                                          input logic [7:0] v,
                                          input logic c,
                                          input logic t,
                                          input logic [2:0] b);
    logic [7:0] r;
    r = v;
    unique case (op)
      csbe_pkg::OP_LOGIC_SHIFT_LEFT:   return {v[7], v[6:0], 1'b0};
      csbe_pkg::OP_LOGIC_SHIFT_RIGHT:  return {v[0], 1'b0, v[7:1]};
      csbe_pkg::OP_ARITH_SHIFT_RIGHT:  return {v[0], v[7], v[7:1]};
      csbe_pkg::OP_ROTATE_LEFT_CARRY:  return {v[7], v[6:0], c};
      csbe_pkg::OP_ROTATE_RIGHT_CARRY: return {v[0], c, v[7:1]};
      csbe_pkg::OP_SWAP_NIBBLES:       return {c, v[3:0], v[7:4]};
      csbe_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
        r[b] = t;
        return {c, r};
      end
      default:                         return {c, v};
    endcase
  endfunction

  // Operation classes
  function automatic logic is_shift(input csbe_pkg::csbe_op_t op);
    return op inside {csbe_pkg::OP_LOGIC_SHIFT_LEFT,
                      csbe_pkg::OP_LOGIC_SHIFT_RIGHT,
                      csbe_pkg::OP_ROTATE_LEFT_CARRY,
                      csbe_pkg::OP_ROTATE_RIGHT_CARRY,
                      csbe_pkg::OP_ARITH_SHIFT_RIGHT};
  endfunction

  function automatic logic is_pml(input csbe_pkg::csbe_op_t op);
    return op inside {csbe_pkg::OP_PML_R0, csbe_pkg::OP_PML,
                      csbe_pkg::OP_PML_INC};
  endfunction

  function automatic logic is_dm_write(input csbe_pkg::csbe_op_t op);
    return op inside {csbe_pkg::OP_ST_ZINC, csbe_pkg::OP_ST_ZDEC,
                      csbe_pkg::OP_ST_ZDISP, csbe_pkg::OP_STORE_DIRECT,
                      csbe_pkg::OP_PUSH};
  endfunction

  function automatic logic is_iobit(input csbe_pkg::csbe_op_t op);
    return op inside {csbe_pkg::OP_IO_BIT_SET, csbe_pkg::OP_IO_BIT_CLEAR};
  endfunction

  // Operand fetch and acceptance
  wire logic [15:0] z_ptr   = {rf_q[csbe_pkg::REG_ZH], rf_q[csbe_pkg::REG_ZL]};
  wire logic [7:0]  src_val = rf_q[i_reg];
  wire logic        idle    = state_q == csbe_pkg::ST_IDLE;
  wire logic        run_en  = ctrl_q[csbe_pkg::CTRL_RUN];
  wire logic        accept  = idle && run_en && i_op_valid;
  wire logic        brk_act = accept && i_op == csbe_pkg::OP_BREAK
                              && ctrl_q[csbe_pkg::CTRL_DBG];
  wire logic [8:0]  alu_out = alu_calc(i_op, src_val, flags_q[csbe_pkg::FLG_C],
                                       flags_q[csbe_pkg::FLG_T], i_bit);
  wire logic [7:0]  bit_msk = 8'h01 << i_bit;
  wire logic [15:0] z_disp  = z_ptr + {10'h000, i_imm[csbe_pkg::DISP_W-1:0]};

  // Address latched for the later cycles of a multi-cycle op
  logic [15:0] addr_d;
  always_comb begin
    unique case (i_op)
      csbe_pkg::OP_ST_ZDEC:      addr_d = z_ptr - 16'h0001;
      csbe_pkg::OP_ST_ZDISP:     addr_d = z_disp;
      csbe_pkg::OP_STORE_DIRECT: addr_d = i_imm;
      csbe_pkg::OP_PUSH:         addr_d = sp_q;
      csbe_pkg::OP_POP:          addr_d = sp_q + 16'h0001;
      csbe_pkg::OP_IO_BIT_SET,
      csbe_pkg::OP_IO_BIT_CLEAR: addr_d = {10'h000, i_imm[csbe_pkg::IO_W-1:0]};
      default:                   addr_d = z_ptr;
    endcase
  end

  // Read-modify-write value for the I/O bit ops
  wire logic [7:0] data_d = (i_op == csbe_pkg::OP_IO_BIT_SET)
                            ? (i_io_rdata | bit_msk)
                            : (i_op == csbe_pkg::OP_IO_BIT_CLEAR)
                            ? (i_io_rdata & ~bit_msk)
                            : src_val;

  // Pointer updates at acceptance
  wire logic        z_we = accept && (i_op == csbe_pkg::OP_ST_ZINC
                                   || i_op == csbe_pkg::OP_PML_INC
                                   || i_op == csbe_pkg::OP_ST_ZDEC);
  wire logic [15:0] z_d  = (i_op == csbe_pkg::OP_ST_ZDEC)
                           ? z_ptr - 16'h0001
                           : z_ptr + 16'h0001;

  // General register write port
  wire logic wr_alu  = accept && (is_shift(i_op)
                         || i_op == csbe_pkg::OP_SWAP_NIBBLES
                         || i_op == csbe_pkg::OP_TRANSFER_FLAG_TO_BIT);
  wire logic wr_in   = accept && i_op == csbe_pkg::OP_PORT_IN;
  wire logic wr_pop  = state_q == csbe_pkg::ST_EX2
                       && op_q == csbe_pkg::OP_POP;
  wire logic wr_pml  = state_q == csbe_pkg::ST_EX3;
  wire logic        rf_we    = wr_alu || wr_in || wr_pop || wr_pml;
  wire logic [4:0]  rf_waddr = (wr_pop || wr_pml) ? reg_q : i_reg;
  wire logic [7:0]  pm_byte  = addr_q[0] ? i_pm_rdata[15:8] : i_pm_rdata[7:0];
  wire logic [7:0]  rf_wdata = wr_pml ? pm_byte
                             : wr_pop ? i_dm_rdata
                             : wr_in  ? i_io_rdata
                             : alu_out[7:0];

  // Bus outputs; strobes stand only in the access cycle, o_pm_we until i_pm_done
  wire logic ex2 = state_q == csbe_pkg::ST_EX2;
  assign o_dm_addr  = addr_q;
  assign o_dm_wdata = data_q;
  assign o_dm_we    = ex2 && is_dm_write(op_q);
  assign o_dm_re    = ex2 && op_q == csbe_pkg::OP_POP;
  assign o_pm_addr  = addr_q[15:1];
  assign o_pm_re    = ex2 && is_pml(op_q);
  assign o_pm_we    = state_q == csbe_pkg::ST_PMW;
  assign o_pm_wdata = pmw_q;
  assign o_io_re    = accept && (i_op == csbe_pkg::OP_PORT_IN
                                 || is_iobit(i_op));
  assign o_io_we    = (accept && i_op == csbe_pkg::OP_PORT_OUT)
                      || (ex2 && is_iobit(op_q));
  assign o_io_addr  = ex2 ? addr_q[5:0] : i_imm[csbe_pkg::IO_W-1:0];
  assign o_io_wdata = ex2 ? data_q : src_val;
  assign o_sleep_req   = accept && i_op == csbe_pkg::OP_SLEEP;
  assign o_wdt_restart = accept && i_op == csbe_pkg::OP_WATCHDOG_RESTART;
  assign o_debug_halt  = state_q == csbe_pkg::ST_BRK;
  assign o_op_ready    = idle && run_en;

  // Retirement pulse on the last cycle of every op
  wire logic one_cyc = !(is_dm_write(i_op) || is_pml(i_op) || is_iobit(i_op)
                         || i_op == csbe_pkg::OP_POP
                         || i_op == csbe_pkg::OP_PROGRAM_MEM_STORE || brk_act);
  assign o_op_done = (accept && one_cyc) || (ex2 && !is_pml(op_q)) || wr_pml
                     || (o_pm_we && i_pm_done)
                     || (o_debug_halt && i_debug_resume);

  // Sequencer: 2-cycle ops pass EX2, program memory loads add EX3
  csbe_pkg::csbe_state_t state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      csbe_pkg::ST_IDLE: begin
        if (accept && !one_cyc) begin
          if (i_op == csbe_pkg::OP_PROGRAM_MEM_STORE) begin
            state_d = csbe_pkg::ST_PMW;
          end else if (brk_act) begin
            state_d = csbe_pkg::ST_BRK;
          end else begin
            state_d = csbe_pkg::ST_EX2;
          end
        end
      end
      csbe_pkg::ST_EX2: begin
        state_d = is_pml(op_q) ? csbe_pkg::ST_EX3 : csbe_pkg::ST_IDLE;
      end
      csbe_pkg::ST_EX3: state_d = csbe_pkg::ST_IDLE;
      csbe_pkg::ST_PMW: begin
        if (i_pm_done) begin
          state_d = csbe_pkg::ST_IDLE;
        end
      end
      csbe_pkg::ST_BRK: begin
        if (i_debug_resume) begin
          state_d = csbe_pkg::ST_IDLE;
        end
      end
      default: state_d = csbe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= csbe_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Operand latches for later cycles
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q   <= csbe_pkg::OP_NOP;
      reg_q  <= 5'h00;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      pmw_q  <= 16'h0000;
    end else if (accept) begin
      op_q   <= i_op;
      reg_q  <= (i_op == csbe_pkg::OP_PML_R0) ? csbe_pkg::REG_R0 : i_reg;
      addr_q <= addr_d;
      data_q <= data_d;
      pmw_q  <= {rf_q[csbe_pkg::REG_R1], rf_q[csbe_pkg::REG_R0]};
    end
  end

  // Register file; Z update then data write, never on the same entry
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      if (z_we) begin
        rf_q[csbe_pkg::REG_ZL] <= z_d[7:0];
        rf_q[csbe_pkg::REG_ZH] <= z_d[15:8];
      end
      if (rf_we) begin
        rf_q[rf_waddr] <= rf_wdata;
      end
    end
  end

  // Status flags; stores, loads, push and pop leave them alone
  logic [7:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (accept && is_shift(i_op)) begin
      flags_d[csbe_pkg::FLG_C] = alu_out[8];
      flags_d[csbe_pkg::FLG_Z] = alu_out[7:0] == 8'h00;
      flags_d[csbe_pkg::FLG_N] = alu_out[7];
      flags_d[csbe_pkg::FLG_V] = alu_out[7] ^ alu_out[8];
    end
    if (accept && i_op == csbe_pkg::OP_FLAG_SET_GENERIC) begin
      flags_d[i_bit] = 1'b1;
    end
    if (accept && i_op == csbe_pkg::OP_FLAG_CLEAR_GENERIC) begin
      flags_d[i_bit] = 1'b0;
    end
    if (accept && i_op == csbe_pkg::OP_BIT_TO_TRANSFER_FLAG) begin
      flags_d[csbe_pkg::FLG_T] = src_val[i_bit];
    end
  end

  // APB decode; zero wait states, unmapped offsets answer with error
  wire logic apb_setup = psel && !penable;
  wire logic apb_wr    = psel && penable && pwrite;
  wire logic hit_ctrl  = paddr == csbe_pkg::OFS_CTRL;
  wire logic hit_flags = paddr == csbe_pkg::OFS_FLAGS;
  wire logic hit_sp    = paddr == csbe_pkg::OFS_SP;
  wire logic hit_zptr  = paddr == csbe_pkg::OFS_ZPTR;
  wire logic hit_state = paddr == csbe_pkg::OFS_STATE;
  wire logic hit_any   = hit_ctrl || hit_flags || hit_sp || hit_zptr
                         || hit_state;
  wire logic [31:0] rd_mux = hit_ctrl  ? {30'h0, ctrl_q}
                           : hit_flags ? {24'h0, flags_q}
                           : hit_sp    ? {16'h0, sp_q}
                           : hit_zptr  ? {16'h0, z_ptr}
                           : hit_state ? {29'h0, state_q}
                           : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata  = prdata_q;

  // Software writes land after the core's own update in the same cycle
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_q   <= csbe_pkg::CTRL_RESET;
      flags_q  <= csbe_pkg::FLAGS_RESET;
      sp_q     <= SP_RESET;
      prdata_q <= 32'h0;
    end else begin
      flags_q <= flags_d;
      if (accept && i_op == csbe_pkg::OP_PUSH) begin
        sp_q <= sp_q - 16'h0001;
      end else if (accept && i_op == csbe_pkg::OP_POP) begin
        sp_q <= sp_q + 16'h0001;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (apb_wr && hit_flags) begin
        flags_q <= pwdata[7:0];
      end
      if (apb_wr && hit_sp) begin
        sp_q <= pwdata[15:0];
      end
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// >>> inc/csbe_pkg.sv
package csbe_pkg;

  // Operations presented by the decoder
  typedef enum logic [4:0] {
    OP_NOP, OP_ST_ZINC, OP_ST_ZDEC, OP_ST_ZDISP, OP_STORE_DIRECT,
    OP_PML_R0, OP_PML, OP_PML_INC, OP_PROGRAM_MEM_STORE,
    OP_PORT_IN, OP_PORT_OUT, OP_PUSH, OP_POP,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_SWAP_NIBBLES,
    OP_FLAG_SET_GENERIC, OP_FLAG_CLEAR_GENERIC,
    OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
    OP_SLEEP, OP_WATCHDOG_RESTART, OP_BREAK
  } csbe_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EX2, ST_EX3, ST_PMW, ST_BRK
  } csbe_state_t;

  // Status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // Register file indices
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [4:0] REG_R1 = 5'h01;
  localparam logic [4:0] REG_ZL = 5'h1e;
  localparam logic [4:0] REG_ZH = 5'h1f;

  localparam int DISP_W = 6;
  localparam int IO_W   = 6;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_SP     = 8'h08;
  localparam logic [7:0] OFS_ZPTR   = 8'h0c;
  localparam logic [7:0] OFS_STATE  = 8'h10;
  localparam int         CTRL_RUN   = 0;
  localparam int         CTRL_DBG   = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// >>> testbench/cpu_store_bit_control_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_store_bit_control_exec_bench;
  localparam logic [15:0] SPR = 16'h045f;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, i_op_valid = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, i_debug_resume = 1'b0;
  csbe_pkg::csbe_op_t i_op = csbe_pkg::OP_NOP;
  logic [4:0]  i_reg = 5'h00;
  logic [2:0]  i_bit = 3'h0;
  logic [15:0] i_imm = 16'h0000;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pm_wait = 4'h0;
  wire logic o_op_ready, o_op_done, o_dm_we, o_dm_re, o_pm_re, o_pm_we;
  wire logic i_pm_done, o_io_re, o_io_we, pready, pslverr;
  wire logic o_sleep_req, o_wdt_restart, o_debug_halt;
  wire logic [15:0] o_dm_addr, o_pm_wdata, i_pm_rdata;
  wire logic [14:0] o_pm_addr;
  wire logic [7:0]  i_dm_rdata, i_io_rdata, o_dm_wdata, o_io_wdata;
  wire logic [5:0]  o_io_addr;
  wire logic [31:0] prdata;
  int fails = 0, tests_run = 0, hc = 0;
  logic [7:0]  r [32], iom [64], fl;
  logic [15:0] sp, z, ad;
  logic [39:0] q [$];
  csbe_exec #(.SP_RESET(SPR)) uut (.*);
  csbe_mem_model mem (.i_mclk(i_mclk), .i_dm_addr(o_dm_addr),
    .i_dm_we(o_dm_we), .i_dm_re(o_dm_re), .i_dm_wdata(o_dm_wdata),
    .o_dm_rdata(i_dm_rdata), .i_pm_addr(o_pm_addr), .i_pm_re(o_pm_re),
    .i_pm_we(o_pm_we), .i_pm_wait(pm_wait), .o_pm_rdata(i_pm_rdata),
    .o_pm_done(i_pm_done), .i_io_addr(o_io_addr), .i_io_re(o_io_re),
    .i_io_we(o_io_we), .i_io_wdata(o_io_wdata), .o_io_rdata(i_io_rdata));
  always #2.5 i_mclk = ~i_mclk;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [39:0] got, logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Every data and I/O write strobe, and a program store only in its i_pm_done cycle, takes the oldest note
  task automatic see(logic [39:0] v);
    chk("write", v, q.size() > 0 ? q.pop_front() : 40'hx);
  endtask
  always @(negedge i_mclk) begin
    if (o_dm_we === 1'b1) see({8'h01, o_dm_addr, 8'h00, o_dm_wdata});
    if (o_io_we === 1'b1) see({18'h08000, o_io_addr, 8'h00, o_io_wdata});
    if (o_pm_we === 1'b1 && i_pm_done === 1'b1)
      see({9'h006, o_pm_addr, o_pm_wdata});
  end
  // Debugger lets a halted core go after a few cycles
  always @(posedge i_mclk) begin
    hc <= (o_debug_halt === 1'b1) ? hc + 1 : 0;
    i_debug_resume <= (hc == 4);
  end
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge i_mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, rd, e);
    chk("apb read", {7'h0, e, rd}, {8'h0, exp});
  endtask
  // Offer one op, count cycles from take to done
  task automatic run(csbe_pkg::csbe_op_t o, int rg, int b, logic [15:0] v,
                     int cyc);
    int   n;
    logic d;
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op <= o;
    i_reg <= 5'(rg);
    i_bit <= 3'(b);
    i_imm <= v;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_op_ready !== 1'b1 && n < 50);
    n = 1;
    d = o_op_done;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    while (d !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
      d = o_op_done;
    end
    if (n >= 60) begin
      fails++;
      stop_test();
    end
    if (cyc > 0) chk("cycles", 40'(n), 40'(cyc));
  endtask
  task automatic show(int rg);
    q.push_back({18'h08000, 6'h3f, 8'h00, r[rg]});
    run(csbe_pkg::OP_PORT_OUT, rg, 0, 16'h003f, 1);
  endtask
  function automatic logic [8:0] shf(int k, logic [7:0] v, logic c);
    case (k)
      0: return {v, 1'b0};
      1: return {v[0], 1'b0, v[7:1]};
      2: return {v, c};
      3: return {v[0], c, v[7:1]};
      4: return {v[0], v[7], v[7:1]};
      default: return {c, v[3:0], v[7:4]};
    endcase
  endfunction
  initial begin
    repeat (90000) @(posedge i_mclk);
    fails++;
    stop_test();
  end
  initial begin
    logic [31:0] rd;
    logic [8:0]  s;
    logic        e;
    int          p, b;
    void'($urandom(32'h704e));
    for (int i = 0; i < 256; i++) mem.dm[i] = 8'($urandom);
    for (int i = 0; i < 64; i++) iom[i] = 8'($urandom);
    for (int i = 0; i < 64; i++) mem.io[i] = iom[i];
    sp = SPR;
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rchk(csbe_pkg::OFS_CTRL, 32'(csbe_pkg::CTRL_RESET));
    rchk(csbe_pkg::OFS_FLAGS, 32'(csbe_pkg::FLAGS_RESET));
    rchk(csbe_pkg::OFS_SP, 32'(SPR));
    apb(1'b0, 8'h14, 32'h0, rd, e);
    chk("unmapped", {7'h0, e, rd}, 40'h100000000);
    for (int i = 0; i < 32; i++) begin
      r[i] = iom[i];
      run(csbe_pkg::OP_PORT_IN, i, 0, 16'(i), 1);
    end
    fl = 8'($urandom);
    apb(1'b1, csbe_pkg::OFS_FLAGS, 32'(fl), rd, e);
    // Stores of each addressing form with random operands
    for (int i = 0; i < 8; i++) begin
      p = $urandom_range(29);
      ad = 16'($urandom);
      z = {r[31], r[30]};
      if (i % 4 == 0) {r[31], r[30]} = z + 16'h1;
      if (i % 4 == 1) {r[31], r[30]} = z - 16'h1;
      q.push_back({8'h01, (i % 4 == 3) ? ad : (i % 4 == 2) ?
        z + 16'(ad[5:0]) : z - 16'(i % 4), 8'h00, r[p]});
      run(csbe_pkg::csbe_op_t'(1 + i % 4), p, 0, ad, 2);
      rchk(csbe_pkg::OFS_ZPTR, {16'h0, r[31], r[30]});
    end
    // Push then two pops walk the stack both ways
    q.push_back({8'h01, sp, 8'h00, r[4]});
    run(csbe_pkg::OP_PUSH, 4, 0, 16'h0, 2);
    sp = sp - 16'h1;
    rchk(csbe_pkg::OFS_SP, 32'(sp));
    for (int i = 0; i < 2; i++) begin
      sp = sp + 16'h1;
      r[9 + i] = mem.dm[sp[7:0]];
      run(csbe_pkg::OP_POP, 9 + i, 0, 16'h0, 2);
      show(9 + i);
    end
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 0 : 11;
      z = {r[31], r[30]};
      r[p] = z[0] ? ~z[8:1] : z[8:1];
      if (i == 2) {r[31], r[30]} = z + 16'h1;
      run(csbe_pkg::csbe_op_t'(5 + i), 11, 0, 16'h0, 3);
      show(p);
    end
    rchk(csbe_pkg::OFS_ZPTR, {16'h0, r[31], r[30]});
    rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    for (int i = 0; i < 4; i++) begin
      p = $urandom_range(62);
      b = $urandom_range(7);
      iom[p] = mem.io[p];
      iom[p][b] = (i % 2 == 0);
      q.push_back({18'h08000, 6'(p), 8'h00, iom[p]});
      run(csbe_pkg::csbe_op_t'(13 + i % 2), 0, b, 16'(p), 2);
    end
    for (int i = 0; i < 12; i++) begin
      fl = 8'($urandom);
      apb(1'b1, csbe_pkg::OFS_FLAGS, 32'(fl), rd, e);
      s = shf(i % 6, r[5], fl[0]);
      r[5] = s[7:0];
      if (i % 6 < 5) fl[3:0] = {s[7] ^ s[8], s[7], s[7:0] == 8'h0, s[8]};
      run(csbe_pkg::csbe_op_t'(15 + i % 6), 5, 0, 16'h0, 1);
      show(5);
      rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    end
    for (int i = 0; i < 16; i++) begin
      fl[i / 2] = (i % 2 == 0);
      run(csbe_pkg::csbe_op_t'(21 + i % 2), 0, i / 2, 16'h0, 1);
      rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    end
    for (int i = 0; i < 4; i++) begin
      b = $urandom_range(7);
      fl[6] = r[5][b];
      run(csbe_pkg::OP_BIT_TO_TRANSFER_FLAG, 5, b, 16'h0, 1);
      r[7][7 - b] = fl[6];
      run(csbe_pkg::OP_TRANSFER_FLAG_TO_BIT, 7, 7 - b, 16'h0, 1);
      show(7);
      rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    end
    for (int i = 0; i < 4; i++)
      run(csbe_pkg::csbe_op_t'(i == 0 ? 0 : 24 + i), 0, 0, 16'h0, 1);
    apb(1'b1, csbe_pkg::OFS_CTRL, 32'h3, rd, e);
    run(csbe_pkg::OP_BREAK, 0, 0, 16'h0, 0);
    rchk(csbe_pkg::OFS_STATE, 32'h0);
    rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    for (int i = 0; i < 2; i++) begin
      @(posedge i_mclk);
      pm_wait <= 4'(1 + 5 * i);
      z = {r[31], r[30]};
      q.push_back({9'h006, z[15:1], r[1], r[0]});
      run(csbe_pkg::OP_PROGRAM_MEM_STORE, 0, 0, 16'h0, 0);
    end
    rchk(csbe_pkg::OFS_FLAGS, 32'(fl));
    chk("notes left", 40'(q.size()), 40'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// >>> testbench/csbe_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
module csbe_exec_chk (
  input wire logic               i_mclk,
  input wire logic               i_reset_n,
  input wire logic               i_op_valid,
  input wire csbe_pkg::csbe_op_t i_op,
  input wire logic               o_op_ready,
  input wire logic               o_op_done,
  input wire logic               o_dm_we,
  input wire logic               o_dm_re,
  input wire logic               o_pm_re,
  input wire logic               o_pm_we,
  input wire logic               i_pm_done,
  input wire logic               o_io_re,
  input wire logic               o_io_we,
  input wire logic               o_sleep_req,
  input wire logic               o_wdt_restart,
  input wire logic               o_debug_halt
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Classes of the operation taken at this edge
  wire logic acc = i_op_valid && o_op_ready;
  wire logic wr2 = acc && i_op inside {[csbe_pkg::OP_ST_ZINC:
    csbe_pkg::OP_STORE_DIRECT], csbe_pkg::OP_PUSH};
  wire logic two = wr2 || (acc && i_op inside {[csbe_pkg::OP_POP:
    csbe_pkg::OP_IO_BIT_CLEAR]});
  wire logic one = acc && i_op inside {[csbe_pkg::OP_LOGIC_SHIFT_LEFT:
    csbe_pkg::OP_WATCHDOG_RESTART], csbe_pkg::OP_PORT_IN,
    csbe_pkg::OP_PORT_OUT, csbe_pkg::OP_NOP};
  wire logic pml = acc && i_op inside {[csbe_pkg::OP_PML_R0:
    csbe_pkg::OP_PML_INC]};
  wire logic iob = acc && i_op inside {[csbe_pkg::OP_IO_BIT_SET:
    csbe_pkg::OP_IO_BIT_CLEAR]};
  wire logic pop = acc && i_op == csbe_pkg::OP_POP;
  wire logic slp = acc && i_op == csbe_pkg::OP_SLEEP;
  wire logic watchdog_restart = acc && i_op == csbe_pkg::OP_WATCHDOG_RESTART;
  sequence s_c2;
    !o_op_done ##1 (o_op_done && !o_op_ready) ##1 o_op_ready;
  endsequence
  sequence s_c3;
    !o_op_done ##1 (o_pm_re && !o_op_done) ##1 o_op_done;
  endsequence
  property p_two; two |-> s_c2; endproperty
  property p_one; one |-> o_op_done; endproperty
  property p_wr; wr2 |=> o_dm_we && !o_dm_re; endproperty
  property p_pop; pop |=> o_dm_re && !o_dm_we; endproperty
  property p_pml; pml |-> s_c3; endproperty
  property p_iob; iob |-> o_io_re && !o_io_we ##1 o_io_we; endproperty
  property p_slp; o_sleep_req == slp && (!slp || o_op_done); endproperty
  property p_wdr; o_wdt_restart == watchdog_restart && (!watchdog_restart || o_op_done); endproperty
  property p_pmw;
    o_pm_we |-> if (i_pm_done) o_op_done else ##1 o_pm_we;
  endproperty
  property p_brk; o_debug_halt |-> !o_op_ready; endproperty
  a_two: assert property (p_two)
    else $error("two cycle op timing wrong");
  a_one: assert property (p_one)
    else $error("single cycle op not done at once");
  a_wr: assert property (p_wr)
    else $error("store without data write");
  a_pop: assert property (p_pop)
    else $error("pop without data read");
  a_pml: assert property (p_pml)
    else $error("program load timing wrong");
  a_iob: assert property (p_iob)
    else $error("io bit read then write missing");
  a_slp: assert property (p_slp)
    else $error("sleep request wrong");
  a_wdr: assert property (p_wdr)
    else $error("watchdog restart pulse wrong");
  a_pmw: assert property (p_pmw)
    else $error("program store ended early or late");
  a_brk: assert property (p_brk)
    else $error("ready while halted");
endmodule
bind csbe_exec csbe_exec_chk u_chk (.i_mclk, .i_reset_n, .i_op_valid,
  .i_op, .o_op_ready, .o_op_done, .o_dm_we, .o_dm_re, .o_pm_re, .o_pm_we,
  .i_pm_done, .o_io_re, .o_io_we, .o_sleep_req, .o_wdt_restart,
  .o_debug_halt);
`default_nettype wire

// >>> testbench/csbe_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csbe_mem_model (
  input  wire logic        i_mclk,
  input  wire logic [15:0] i_dm_addr,
  input  wire logic        i_dm_we,
  input  wire logic        i_dm_re,
  input  wire logic [7:0]  i_dm_wdata,
  output logic [7:0]       o_dm_rdata,
  input  wire logic [14:0] i_pm_addr,
  input  wire logic        i_pm_re,
  input  wire logic        i_pm_we,
  input  wire logic [3:0]  i_pm_wait,
  output logic [15:0]      o_pm_rdata,
  output logic             o_pm_done,
  input  wire logic [5:0]  i_io_addr,
  input  wire logic        i_io_re,
  input  wire logic        i_io_we,
  input  wire logic [7:0]  i_io_wdata,
  output logic [7:0]       o_io_rdata
);
  logic [7:0]  dm [256];
  logic [7:0]  io [64];
  logic [15:0] pm_q;
  logic [3:0]  wait_q;
  // Unread buses show the inverted cell so stale data never matches
  assign o_dm_rdata = i_dm_re ? dm[i_dm_addr[7:0]] : ~dm[i_dm_addr[7:0]];
  assign o_io_rdata = i_io_re ? io[i_io_addr] : ~io[i_io_addr];
  assign o_pm_rdata = pm_q;
  assign o_pm_done  = i_pm_we && wait_q == i_pm_wait;
  // Only low address bits decoded; bench may preload both arrays
  always @(posedge i_mclk) begin
    if (i_dm_we) dm[i_dm_addr[7:0]] <= i_dm_wdata;
    if (i_io_we) io[i_io_addr] <= i_io_wdata;
    pm_q <= i_pm_re ? {~i_pm_addr[7:0], i_pm_addr[7:0]} : ~pm_q;
    wait_q <= i_pm_we ? wait_q + 4'h1 : 4'h0;
  end
endmodule
`default_nettype wire
